// ### logic/playfield_regs.vh
// register offsets, field positions and reset values of the playfield fetch block
`ifndef PLAYFIELD_REGS_VH
`define PLAYFIELD_REGS_VH

// ----------------------------------------------------------------
// register byte offsets on the apb bus
// ----------------------------------------------------------------
`define OFF_MAIN_CTRL 8'h00
`define OFF_PRIO_CTRL 8'h04
`define OFF_ODD_SKIP 8'h08
`define OFF_EVEN_SKIP 8'h0C
`define OFF_FETCH_START 8'h10
`define OFF_FETCH_STOP 8'h14
`define OFF_WIN_START 8'h18
`define OFF_STATUS 8'h1C
`define OFF_PTR_BASE 8'h20
`define OFF_PTR_LAST 8'h34

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BIT_HIRES 15
`define BIT_COUNT_HI 14
`define BIT_COUNT_LO 12
`define BIT_TWO_FIELD 10
`define BIT_SECOND_FRONT 6
`define BIT_LEFT_HI 7
`define BIT_LEFT_LO 0
`define BIT_TOP_HI 15
`define BIT_TOP_LO 8
`define BIT_STAT_FETCH 31

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_SKIP 16'h0000
`define RST_FETCH_START 8'h38
`define RST_FETCH_STOP 8'hD0
`define RST_WIN_START 16'h2C81
`define RST_PTR 32'h0000_0000

// ----------------------------------------------------------------
// counts
// ----------------------------------------------------------------
`define NUM_PLANES 6
`define HIRES_PLANE_LIMIT 3'h4
`define WORD_BYTES 32'h0000_0002

`endif

// ### logic/plane_shifter.v
// per-plane 16-bit shift registers that turn fetched words into pixel bits
module plane_shifter #(
    parameter PLANES = 6,
    parameter WIDTH = 16
) (
    input wire pclk,
    input wire presetn,
    input wire load,
    input wire [PLANES*WIDTH-1:0] load_data,
    input wire step,
    output wire [PLANES-1:0] plane_bits
);

    // ----------------------------------------------------------------
    // one shift register per plane
    // ----------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < PLANES; i = i + 1) begin : lane
            reg [WIDTH-1:0] shift_q; // pixel bits still to show, msb first
            // a load replaces what is left; the fetcher does not wait for the word to shift out
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    shift_q <= {WIDTH{1'b0}};
                end else if (load) begin
                    shift_q <= load_data[i*WIDTH +: WIDTH];
                end else if (step) begin
                    // zero fill so a starved line shows transparent
                    shift_q <= {shift_q[WIDTH-2:0], 1'b0};
                end
            end
            assign plane_bits[i] = shift_q[WIDTH-1];
        end
    endgenerate

endmodule

// ### logic/field_combiner.v
// merges plane bits into one palette index, with dual-field priority
module field_combiner (
    input wire pclk,
    input wire presetn,
    input wire [5:0] plane_bits,
    input wire [2:0] plane_count,
    input wire two_field,
    input wire second_front,
    input wire hires,
    input wire in_window,
    output reg [5:0] pixel_index_q,
    output reg pixel_valid_q
);

    // ----------------------------------------------------------------
    // plane masking
    // ----------------------------------------------------------------
    reg [5:0] used_mask; // planes that carry data this frame
    reg [5:0] bits_m; // plane bits with unused planes forced low
    reg [2:0] odd_idx; // first field colour, planes 1,3,5
    reg [2:0] even_idx; // second field colour, planes 2,4,6
    reg [5:0] index_d;
    integer k;

    // ----------------------------------------------------------------
    // colour selection
    // ----------------------------------------------------------------
    always @* begin
        used_mask = 6'h00;
        for (k = 0; k < 6; k = k + 1) begin
            used_mask[k] = (k < plane_count);
        end
        // hires dual mode keeps only two planes per field
        if (hires && two_field) begin
            used_mask = used_mask & 6'h0F;
        end
        bits_m = plane_bits & used_mask;
        odd_idx = {bits_m[4], bits_m[2], bits_m[0]};
        even_idx = {bits_m[5], bits_m[3], bits_m[1]};
        index_d = 6'h00;
        if (!in_window) begin
            // outside the window only background shows
            index_d = 6'h00;
        end else if (!two_field) begin
            index_d = bits_m;
        end else if (second_front) begin
            // zero index is see-through, so the field behind shows
            if (even_idx != 3'h0) begin
                index_d = {3'h1, even_idx};
            end else if (odd_idx != 3'h0) begin
                index_d = {3'h0, odd_idx};
            end
        end else begin
            if (odd_idx != 3'h0) begin
                index_d = {3'h0, odd_idx};
            end else if (even_idx != 3'h0) begin
                index_d = {3'h1, even_idx};
            end
        end
    end

    // ----------------------------------------------------------------
    // output register
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pixel_index_q <= 6'h00;
            pixel_valid_q <= 1'b0;
        end else begin
            pixel_index_q <= index_d;
            pixel_valid_q <= in_window;
        end
    end

endmodule

// ### logic/dual_playfield_fetch_window.v
// playfield fetch engine with apb registers, raster counters and pixel path
`include "playfield_regs.vh"

module dual_playfield_fetch_window #(
    parameter LINE_PIXELS = 454,
    parameter FRAME_LINES = 262
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata_q,
    output reg pready_q,
    output reg pslverr_q,
    output reg mem_req_q,
    output reg [31:0] mem_addr_q,
    input wire mem_ack,
    input wire [15:0] mem_rdata,
    output wire [5:0] pixel_index_q,
    output wire pixel_valid_q
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    localparam NP = `NUM_PLANES;
    localparam [2:0] ST_IDLE = 3'b001; // waiting for fetch start
    localparam [2:0] ST_REQ = 3'b010; // fetching one plane word
    localparam [2:0] ST_SKIP = 3'b100; // adding line modulo

    reg hires_q; // high resolution mode
    reg [2:0] count_q; // planes in use
    reg two_field_q; // dual-playfield mode
    reg second_front_q; // second field shown in front
    reg [15:0] odd_skip_q; // odd plane line modulo
    reg [15:0] even_skip_q; // even plane line modulo
    reg [7:0] fetch_start_q; // fetch start, colour clocks
    reg [7:0] fetch_stop_q; // fetch stop, colour clocks
    reg [15:0] win_start_q; // window left and top corner
    reg sub_q; // half of a lores pixel
    reg [8:0] hpos_q; // lores pixel within line
    reg [8:0] vpos_q; // line within frame
    reg armed_q; // fetch not yet begun on this line
    reg [2:0] state_q;
    reg [2:0] plane_q; // plane being fetched
    reg [6:0] words_left_q; // words per plane still to fetch
    reg [NP*16-1:0] buf_q; // assembled word set
    reg load_q; // word set ready for the shifter
    wire [NP*32-1:0] ptr_flat; // current pointer of every plane
    wire [NP-1:0] plane_bits;
    wire [7:0] fetch_span;
    wire [6:0] lores_words;
    wire [6:0] line_words;
    wire [2:0] eff_count;
    wire setup;
    wire wr_en;
    wire [7:0] win_left;
    wire [7:0] win_top;
    wire in_window;
    wire fetch_go;
    wire step;
    wire [2:0] ptr_sel;
    reg [31:0] rdata_d;
    reg err_d;

    assign setup = psel & ~penable;
    assign wr_en = setup & pwrite;
    assign ptr_sel = paddr[4:2] - 3'h0; // pointer slot from offset 0x20
    assign win_left = win_start_q[`BIT_LEFT_HI:`BIT_LEFT_LO];
    assign win_top = win_start_q[`BIT_TOP_HI:`BIT_TOP_LO];

    // ----------------------------------------------------------------
    // apb register writes
    // ----------------------------------------------------------------
    // writes take effect on the setup edge so pready can be a flop
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hires_q <= 1'b0;
            count_q <= 3'h0;
            two_field_q <= 1'b0;
            second_front_q <= 1'b0;
            odd_skip_q <= `RST_SKIP;
            even_skip_q <= `RST_SKIP;
            fetch_start_q <= `RST_FETCH_START;
            fetch_stop_q <= `RST_FETCH_STOP;
            win_start_q <= `RST_WIN_START;
        end else if (wr_en) begin
            case (paddr)
                `OFF_MAIN_CTRL: begin
                    hires_q <= pwdata[`BIT_HIRES];
                    count_q <= pwdata[`BIT_COUNT_HI:`BIT_COUNT_LO];
                    two_field_q <= pwdata[`BIT_TWO_FIELD];
                end
                `OFF_PRIO_CTRL: second_front_q <= pwdata[`BIT_SECOND_FRONT];
                `OFF_ODD_SKIP: odd_skip_q <= pwdata[15:0];
                `OFF_EVEN_SKIP: even_skip_q <= pwdata[15:0];
                `OFF_FETCH_START: fetch_start_q <= pwdata[7:0];
                `OFF_FETCH_STOP: fetch_stop_q <= pwdata[7:0];
                `OFF_WIN_START: win_start_q <= pwdata[15:0];
                default: begin
                    // pointers and read-only words are handled elsewhere
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // apb read mux and answer
    // ----------------------------------------------------------------
    always @* begin
        rdata_d = 32'h0000_0000;
        err_d = 1'b0;
        if (paddr >= `OFF_PTR_BASE && paddr <= `OFF_PTR_LAST && paddr[1:0] == 2'h0) begin
            rdata_d = ptr_flat[ptr_sel*32 +: 32];
        end else begin
            case (paddr)
                `OFF_MAIN_CTRL: begin
                    rdata_d[`BIT_HIRES] = hires_q;
                    rdata_d[`BIT_COUNT_HI:`BIT_COUNT_LO] = count_q;
                    rdata_d[`BIT_TWO_FIELD] = two_field_q;
                end
                `OFF_PRIO_CTRL: rdata_d[`BIT_SECOND_FRONT] = second_front_q;
                `OFF_ODD_SKIP: rdata_d[15:0] = odd_skip_q;
                `OFF_EVEN_SKIP: rdata_d[15:0] = even_skip_q;
                `OFF_FETCH_START: rdata_d[7:0] = fetch_start_q;
                `OFF_FETCH_STOP: rdata_d[7:0] = fetch_stop_q;
                `OFF_WIN_START: rdata_d = 32'h0000_0000; // write-only, reads zero
                `OFF_STATUS: begin
                    rdata_d[8:0] = vpos_q;
                    rdata_d[24:16] = hpos_q;
                    rdata_d[`BIT_STAT_FETCH] = ~state_q[0];
                end
                default: err_d = 1'b1; // unmapped offset
            endcase
        end
    end

    // every access is answered in its first access cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= setup;
            pslverr_q <= setup & err_d;
            if (setup && !pwrite) begin
                prdata_q <= rdata_d;
            end
        end
    end

    // ----------------------------------------------------------------
    // raster counters
    // ----------------------------------------------------------------
    // hpos counts lores pixels; a hires pixel is one clock, lores is two
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sub_q <= 1'b0;
            hpos_q <= 9'h000;
            vpos_q <= 9'h000;
        end else begin
            sub_q <= ~sub_q;
            if (sub_q) begin
                if (hpos_q == LINE_PIXELS - 1) begin
                    hpos_q <= 9'h000;
                    vpos_q <= (vpos_q == FRAME_LINES - 1) ? 9'h000 : vpos_q + 9'h001;
                end else begin
                    hpos_q <= hpos_q + 9'h001;
                end
            end
        end
    end

    // window corner compared in lores, non-interlaced units only
    assign in_window = (hpos_q >= {1'b0, win_left}) &&
                       (vpos_q >= {1'b0, win_top});
    assign step = hires_q | sub_q;

    // ----------------------------------------------------------------
    // fetch sizing
    // ----------------------------------------------------------------
    // eight colour clocks per lores word; hires fetches twice as many
    assign fetch_span = fetch_stop_q - fetch_start_q;
    assign lores_words = {2'b00, fetch_span[7:3]} + 7'h01;
    assign line_words = hires_q ? {lores_words[5:0], 1'b0} : lores_words;
    assign eff_count = (hires_q && two_field_q && count_q > `HIRES_PLANE_LIMIT) ?
                       `HIRES_PLANE_LIMIT : count_q;
    // the same start position opens the fetch for both fields
    assign fetch_go = armed_q && (hpos_q[8:1] == fetch_start_q) &&
                      !hpos_q[0] && sub_q && (eff_count != 3'h0);

    // ----------------------------------------------------------------
    // fetch state machine
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_IDLE;
            plane_q <= 3'h0;
            words_left_q <= 7'h00;
            armed_q <= 1'b0;
            mem_req_q <= 1'b0;
            mem_addr_q <= 32'h0000_0000;
            buf_q <= {NP*16{1'b0}};
            load_q <= 1'b0;
        end else begin
            load_q <= 1'b0;
            if (sub_q && hpos_q == LINE_PIXELS - 1) begin
                armed_q <= 1'b1; // one fetch per line
            end
            case (state_q)
                ST_IDLE: begin
                    if (fetch_go) begin
                        armed_q <= 1'b0;
                        plane_q <= 3'h0;
                        words_left_q <= line_words;
                        mem_req_q <= 1'b1;
                        mem_addr_q <= ptr_flat[31:0];
                        buf_q <= {NP*16{1'b0}};
                        state_q <= ST_REQ;
                    end
                end
                ST_REQ: begin
                    // request holds until memory acknowledges
                    if (mem_ack) begin
                        buf_q[plane_q*16 +: 16] <= mem_rdata;
                        if (plane_q == eff_count - 3'h1) begin
                            load_q <= 1'b1;
                            plane_q <= 3'h0;
                            if (words_left_q == 7'h01) begin
                                mem_req_q <= 1'b0;
                                state_q <= ST_SKIP;
                            end else begin
                                words_left_q <= words_left_q - 7'h01;
                                mem_addr_q <= ptr_flat[31:0] + {30'h0, eff_count == 3'h1, 1'b0};
                            end
                        end else begin
                            plane_q <= plane_q + 3'h1;
                            mem_addr_q <= ptr_flat[(plane_q + 3'h1)*32 +: 32];
                        end
                    end
                end
                ST_SKIP: state_q <= ST_IDLE; // modulo added in this cycle
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // plane pointers
    // ----------------------------------------------------------------
    // odd planes (index 0,2,4) use the odd modulo; a software write wins
    genvar i;
    generate
        for (i = 0; i < NP; i = i + 1) begin : pointer
            reg [31:0] q;
            wire [15:0] skip = (i % 2 == 0) ? odd_skip_q : even_skip_q;
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    q <= `RST_PTR;
                end else if (wr_en && paddr == `OFF_PTR_BASE + 4 * i) begin
                    q <= pwdata;
                end else if (state_q == ST_REQ && mem_ack && plane_q == i) begin
                    q <= q + `WORD_BYTES;
                end else if (state_q == ST_SKIP && i < eff_count) begin
                    // signed modulo lets a still field step back
                    q <= q + {{16{skip[15]}}, skip};
                end
            end
            assign ptr_flat[i*32 +: 32] = q;
        end
    endgenerate

    // ----------------------------------------------------------------
    // pixel path
    // ----------------------------------------------------------------
    plane_shifter #(
        .PLANES(NP),
        .WIDTH(16)
    ) shifter (
        .pclk(pclk),
        .presetn(presetn),
        .load(load_q),
        .load_data(buf_q),
        .step(step),
        .plane_bits(plane_bits)
    );

    field_combiner combiner (
        .pclk(pclk),
        .presetn(presetn),
        .plane_bits(plane_bits),
        .plane_count(eff_count),
        .two_field(two_field_q),
        .second_front(second_front_q),
        .hires(hires_q),
        .in_window(in_window),
        .pixel_index_q(pixel_index_q),
        .pixel_valid_q(pixel_valid_q)
    );

endmodule

// ### testbench/playfield_chk.sv
// port checker for the playfield fetch block
module playfield_chk #(
    parameter LINE_PIXELS = 454,
    parameter FRAME_LINES = 262
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata_q,
    input wire pready_q,
    input wire pslverr_q,
    input wire mem_req_q,
    input wire [31:0] mem_addr_q,
    input wire mem_ack,
    input wire [15:0] mem_rdata,
    input wire [5:0] pixel_index_q,
    input wire pixel_valid_q
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // mode shadow, taken at the setup edge just as the block does
    // ----------------------------------------------------------------
    logic dual_q; // two-field mode
    logic hires_q; // high resolution
    logic [2:0] cnt_q; // active plane count
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // only main control matters for the pixel range checks
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dual_q <= 1'b0;
            hires_q <= 1'b0;
            cnt_q <= 3'h0;
        end else if (psel && !penable && pwrite && paddr == 8'h00) begin
            dual_q <= pwdata[10];
            hires_q <= pwdata[15];
            cnt_q <= pwdata[14:12];
        end
    end
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_wait;
        mem_req_q && !mem_ack;
    endsequence
    AST_READY_NEXT: assert property (s_setup |=> pready_q)
        else $error("no ready after setup");
    AST_READY_PULSE: assert property (pready_q |=> !pready_q)
        else $error("ready held too long");
    AST_ERR_PAIRED: assert property (pslverr_q |-> pready_q)
        else $error("error without ready");
    AST_ERR_UNMAPPED: assert property (s_setup ##0 (paddr > 8'h34) |=> pslverr_q)
        else $error("unmapped access not refused");
    AST_WO_READ: assert property (s_setup ##0 (!pwrite && paddr == 8'h18) |=> prdata_q == 32'h0)
        else $error("window start readable");
    AST_REQ_HOLD: assert property (s_wait |=> mem_req_q && $stable(mem_addr_q))
        else $error("fetch request not held");
    AST_DUAL_LO: assert property (dual_q && !hires_q && pixel_valid_q |->
        pixel_index_q < 6'h10 && pixel_index_q != 6'h08) else $error("bad dual index");
    AST_DUAL_HI: assert property (dual_q && hires_q && pixel_valid_q |->
        pixel_index_q < 6'h04 || (pixel_index_q > 6'h08 && pixel_index_q < 6'h0C))
        else $error("bad hires dual index");
    AST_SINGLE: assert property (!dual_q && pixel_valid_q |-> (pixel_index_q >> cnt_q) == 6'h00)
        else $error("single index beyond plane count");
endmodule

bind dual_playfield_fetch_window playfield_chk #(.LINE_PIXELS(LINE_PIXELS),
    .FRAME_LINES(FRAME_LINES)) playfield_chk_i (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata_q, .pready_q, .pslverr_q, .mem_req_q, .mem_addr_q, .mem_ack,
    .mem_rdata, .pixel_index_q, .pixel_valid_q);

// ### testbench/plane_memory.sv
// behavioural shared memory answering the block's word fetches
module plane_memory (
    input wire pclk,
    input wire presetn,
    input wire mem_req_q,
    input wire [31:0] mem_addr_q,
    input wire [7:0] fill_mask,
    output logic mem_ack,
    output logic [15:0] mem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // random stall, then one acknowledge pulse per word
    // ----------------------------------------------------------------
    logic [1:0] wait_q; // stall cycles left
    // data toggles when not answering, so stale data never looks valid
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_ack <= 1'b0;
            mem_rdata <= 16'h0000;
            wait_q <= 2'h0;
        end else if (mem_ack || !mem_req_q) begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
        end else if (wait_q != 2'h0) begin
            wait_q <= wait_q - 2'h1;
            mem_rdata <= ~mem_rdata;
        end else begin
            mem_ack <= 1'b1;
            wait_q <= 2'($urandom_range(3));
            // fill mode: plane picked by address bits 18:16 is all ones or zeros
            mem_rdata <= (fill_mask == 8'h00) ? (mem_addr_q[16:1] ^ 16'hA5C3) :
                {16{fill_mask[mem_addr_q[18:16]]}};
        end
    end
endmodule

// ### testbench/test_dual_playfield_fetch_window.sv
// self-checking bench for the playfield fetch block
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin error_cnt++; \
    $display("BAD %s exp %h got %h", nm, ex, got); end end
module test_dual_playfield_fetch_window;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // signals and bench state
    // ----------------------------------------------------------------
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [7:0] fill_mask = 8'h00;
    wire [31:0] prdata_q, mem_addr_q;
    wire pready_q, pslverr_q, mem_req_q, mem_ack, pixel_valid_q;
    wire [15:0] mem_rdata;
    wire [5:0] pixel_index_q;
    int error_cnt = 0;
    int compares = 0;
    logic [31:0] rd; // last read data
    logic er; // last error flag
    logic [31:0] ptr[6]; // pointer model
    logic [31:0] skip[2]; // odd, even modulo
    logic armed = 1'b0; // fetch monitor on
    logic pix_on = 1'b0; // pixel monitor on
    int acks, words, planes, pix_seen;
    logic [5:0] pix_exp;
    logic [7:0] reg_off[7] = '{8'h10, 8'h14, 8'h18, 8'h00, 8'h04, 8'h08, 8'h20};
    logic [31:0] reg_rst[7] = '{32'h38, 32'hD0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    // {dual, front, plane fill mask}
    logic [7:0] pix_case[6] = '{8'hBF, 8'hFF, 8'hD5, 8'hAA, 8'h3F, 8'hC9};
    always #12.5 pclk = ~pclk;
    dual_playfield_fetch_window #(.LINE_PIXELS(40), .FRAME_LINES(4)) dual_playfield_fetch_window_i (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata_q, .pready_q,
        .pslverr_q, .mem_req_q, .mem_addr_q, .mem_ack, .mem_rdata, .pixel_index_q,
        .pixel_valid_q);
    plane_memory plane_memory_i (.pclk, .presetn, .mem_req_q, .mem_addr_q, .fill_mask,
        .mem_ack, .mem_rdata);
    // expected colour index of a pixel whose planes follow mask m
    function automatic logic [5:0] pix_fn(input bit dual, input bit front, input [5:0] m);
        logic [2:0] f1;
        logic [2:0] f2;
        f1 = {m[4], m[2], m[0]};
        f2 = {m[5], m[3], m[1]};
        if (!dual) return m;
        if (f2 != 3'h0 && (front || f1 == 3'h0)) return {3'h1, f2};
        return {3'h0, f1};
    endfunction
    // one apb transfer; holds the request until ready is sampled
    task automatic apb(input bit wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready_q !== 1'b1);
        rd = prdata_q;
        er = pslverr_q;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // reset, then program window, fetch span, pointers, modulos and mode
    task automatic setup(input bit hi, input bit dual, input bit front, input [2:0] n);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b1, 8'h18, 32'h0);
        apb(1'b1, 8'h10, 32'h02);
        apb(1'b1, 8'h14, 32'h0A);
        apb(1'b1, 8'h04, {25'h0, front, 6'h0});
        for (int p = 0; p < 6; p++) apb(1'b1, 8'h20 + 8'(p * 4), ptr[p]);
        apb(1'b1, 8'h08, {16'h0, skip[0][15:0]});
        apb(1'b1, 8'h0C, {16'h0, skip[1][15:0]});
        acks = 0;
        planes = n;
        words = hi ? 4 : 2;
        armed <= 1'b1;
        apb(1'b1, 8'h00, {16'h0, hi, n, 1'b0, dual, 10'h0});
    endtask
    // close the run with the counts and the verdict
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // fetch addresses follow the pointer model; shown pixels match
    always @(posedge pclk) begin
        if (armed && mem_req_q && mem_ack) begin
            `CHK("fetch address", ptr[acks % planes], mem_addr_q)
            ptr[acks % planes] += 32'h2;
            acks++;
            if (acks % (planes * words) == 0)
                for (int p = 0; p < planes; p++) ptr[p] += skip[p % 2];
        end
        if (pix_on && pixel_valid_q === 1'b1 && pixel_index_q != 6'h00) begin
            `CHK("pixel index", pix_exp, pixel_index_q)
            pix_seen++;
        end
    end
    // a hang counts as a mismatch
    initial begin
        #1ms;
        error_cnt++;
        give_verdict();
    end
    initial begin
        int n;
        void'($urandom(62355));
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, reg_off[i], 32'h0);
            `CHK("reset value", reg_rst[i], rd)
        end
        apb(1'b1, 8'h08, 32'hFFFF_8002);
        apb(1'b1, 8'h0C, 32'h0000_7FFE);
        apb(1'b0, 8'h08, 32'h0);
        `CHK("odd modulo", 32'h0000_8002, rd)
        apb(1'b1, 8'h18, 32'h0000_FFFF);
        apb(1'b0, 8'h18, 32'h0);
        `CHK("window start read", 32'h0, rd)
        apb(1'b1, 8'h40, 32'h1);
        `CHK("unmapped error", 1'b1, er)
        // random pointers and modulos; odd k steps each line back by half its fetch, modulo -2 or -4
        for (int k = 0; k < 4; k++) begin
            for (int p = 0; p < 6; p++) ptr[p] = $urandom() & 32'hFFFF_FFFE;
            for (int g = 0; g < 2; g++)
                skip[g] = (k % 2) ? -2 * (1 + k / 2) : $urandom_range(255) * 2 - 256;
            setup(k / 2 != 0, 1'b1, 1'b0, 3'h2);
            n = 0;
            while (acks < planes * words * 6 && n < 5000) begin
                @(posedge pclk);
                n++;
            end
            `CHK("lines fetched", 1'b1, acks >= planes * words * 6)
        end
        // plane fill patterns expose grouping and front/back choice
        for (int i = 0; i < 6; i++) begin
            armed = 1'b0;
            pix_on = 1'b0;
            for (int p = 0; p < 6; p++) ptr[p] = 32'h0000_0100 + (p << 16);
            skip[0] = 32'h0;
            skip[1] = 32'h0;
            fill_mask <= {2'h0, pix_case[i][5:0]};
            pix_exp = pix_fn(pix_case[i][7], pix_case[i][6], pix_case[i][5:0]);
            setup(1'b0, pix_case[i][7], pix_case[i][6], 3'h6);
            pix_seen = 0;
            pix_on <= 1'b1;
            repeat (640) @(posedge pclk);
            `CHK("pixels shown", 1'b1, pix_seen > 0)
        end
        give_verdict();
    end
endmodule
